// ===== pcdl_port_mux.sv
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "pcdl_defs.svh"

// Summary of operation
// (RQ1) first port keeps bits 5:0 of data and direction; bits 7:6 read zero
// (RQ2) direction bit one makes a pin input, zero makes it output
// (RQ3) first port data latch unknown at power-on, kept across other resets
// (RQ4) first port direction resets to all ones on every reset
// (RQ5) first port pins shared with timer, capture/pwm and serial port functions
// (RQ6) second port pins 0..4 are bidirectional or lcd segments 0..4
// (RQ7) second port pins 5..7 are digital inputs or lcd segment/common drivers
// (RQ8) second port direction acts only on pins 0..4 while digital
// (RQ9) power-on reset gives all shared pins to the lcd, segment enables ones
// (RQ10) software clears a group enable before using those pins digitally
// (RQ11) a set segment enable overrides direction; lcd drives the pin
// (RQ12) third port is input only; bits 0..6 segments 5..11, bit 7 segment 27
// (RQ13) third port and sixth port pin 7 digital only when groups 5,9,27 clear
// (RQ14) second port direction resets to all ones on every reset
// (RQ15) third port direction resets to all ones on every reset
// (RQ16) reading a port returns pin levels; writing loads the output latch
// (RQ17) an enabled peripheral overrides a first port pin's direction
// (RQ18) group 0 covers second pins 0..4, group 29 pins 5..7; data resets zero
// (RQ19) segment enable register at 10Dh, groups 29,27,20,16,12,9,5,0, read/write

module pcdl_port_mux import pcdl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] first_port_pin_in,
  output logic [5:0] first_port_pin_out,
  output logic [5:0] first_port_pin_oe,
  input wire logic [5:0] periph_en,
  input wire logic [5:0] periph_out,
  input wire logic [5:0] periph_oe,
  input wire logic [7:0] second_port_pin_in,
  output logic [7:0] second_port_pin_out,
  output logic [7:0] second_port_pin_oe,
  input wire logic [7:0] lcd_second_drive,
  input wire logic [7:0] third_port_pin_in,
  output logic [7:0] third_port_pin_out,
  output logic [7:0] third_port_pin_oe,
  input wire logic [7:0] lcd_third_drive,
  output logic [7:0] seg_pin_enable,
  output logic sixth_port_pin7_digital
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[9:0], 2'b00};
  endfunction

  // true when the bus address selects the given register
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr == byte_addr(idx));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic prep;
  logic commit;
  logic addr_hit;

  pcdl_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .addr_hit(addr_hit),
    .prep(prep),
    .commit(commit),
    .pready(pready),
    .pslverr(pslverr)
  );

  // address decode for every mapped word
  always_comb begin
    if (hit(paddr, `PCDL_IDX_FIRST_DATA)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_SECOND_DATA)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_THIRD_DATA)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_FIRST_DIR)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_SECOND_DIR)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_THIRD_DIR)) begin
      addr_hit = 1'b1;
    end else if (hit(paddr, `PCDL_IDX_SEG_ENABLE)) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  pcdl_regs_t r_q;
  pcdl_regs_t r_d;
  logic [7:0] rd_word;
  logic [7:0] wbyte;
  logic third_digital;

  assign wbyte = pwdata[7:0];

  // the third port is released only when all three of its groups are clear
  assign third_digital = ~(r_q.seg_enable[`PCDL_SE_GROUP_5] |
                           r_q.seg_enable[`PCDL_SE_GROUP_9] |
                           r_q.seg_enable[`PCDL_SE_GROUP_27]); // RQ13

  // read mux; port words show the pins, not the latches
  always_comb begin
    if (hit(paddr, `PCDL_IDX_FIRST_DATA)) begin
      rd_word = {2'b00, first_port_pin_in}; // RQ16 RQ1
    end else if (hit(paddr, `PCDL_IDX_SECOND_DATA)) begin
      rd_word = second_port_pin_in; // RQ16
    end else if (hit(paddr, `PCDL_IDX_THIRD_DATA)) begin
      rd_word = third_port_pin_in; // RQ16
    end else if (hit(paddr, `PCDL_IDX_FIRST_DIR)) begin
      rd_word = {2'b00, r_q.first_dir}; // RQ1
    end else if (hit(paddr, `PCDL_IDX_SECOND_DIR)) begin
      rd_word = r_q.second_dir;
    end else if (hit(paddr, `PCDL_IDX_THIRD_DIR)) begin
      rd_word = r_q.third_dir;
    end else if (hit(paddr, `PCDL_IDX_SEG_ENABLE)) begin
      rd_word = r_q.seg_enable; // RQ19
    end else begin
      rd_word = 8'h00;
    end
  end

  // register next state: bus writes, then resets
  always_comb begin
    r_d = r_q;
    r_d.third_pin7_digital = third_digital; // RQ13
    if (prep && !pwrite) begin
      r_d.rdata = {24'h000000, rd_word};
    end
    if (commit && pwrite) begin
      if (hit(paddr, `PCDL_IDX_FIRST_DATA)) begin
        r_d.first_data = wbyte[5:0]; // RQ16 RQ1
      end else if (hit(paddr, `PCDL_IDX_SECOND_DATA)) begin
        r_d.second_data = wbyte; // RQ16
      end else if (hit(paddr, `PCDL_IDX_FIRST_DIR)) begin
        r_d.first_dir = wbyte[5:0]; // RQ1
      end else if (hit(paddr, `PCDL_IDX_SECOND_DIR)) begin
        r_d.second_dir = wbyte;
      end else if (hit(paddr, `PCDL_IDX_THIRD_DIR)) begin
        r_d.third_dir = wbyte;
      end else if (hit(paddr, `PCDL_IDX_SEG_ENABLE)) begin
        r_d.seg_enable = wbyte; // RQ19
      end
    end
    // a non power-on reset wins over a write in the same cycle;
    // the first port latch is deliberately left alone
    if (sys_reset_req) begin
      r_d.first_dir = `PCDL_RST_FIRST_DIR; // RQ4 RQ3
      r_d.second_dir = `PCDL_RST_PORT_DIR; // RQ14
      r_d.third_dir = `PCDL_RST_PORT_DIR; // RQ15
      r_d.second_data = `PCDL_RST_PORT_DATA; // RQ18
      r_d.seg_enable = `PCDL_RST_SEG_ENABLE; // RQ9
    end
  end

  // power-on reset; the first port latch has no defined value, zero is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q.first_data <= `PCDL_RST_FIRST_DATA; // RQ3
      r_q.first_dir <= `PCDL_RST_FIRST_DIR; // RQ4
      r_q.second_data <= `PCDL_RST_PORT_DATA; // RQ18
      r_q.second_dir <= `PCDL_RST_PORT_DIR; // RQ14
      r_q.third_dir <= `PCDL_RST_PORT_DIR; // RQ15
      r_q.seg_enable <= `PCDL_RST_SEG_ENABLE; // RQ9
      r_q.rdata <= 32'h00000000;
      r_q.third_pin7_digital <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign seg_pin_enable = r_q.seg_enable;
  assign sixth_port_pin7_digital = r_q.third_pin7_digital;

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership

  logic [7:0] second_lcd_own;
  logic [7:0] third_lcd_own;

  // group 0 holds pins 0..4, group 29 pins 5..7
  assign second_lcd_own = {{3{r_q.seg_enable[`PCDL_SE_GROUP_29]}},
                           {5{r_q.seg_enable[`PCDL_SE_GROUP_0]}}}; // RQ18 RQ6 RQ7
  // one ownership for the whole third port, matching the release condition
  assign third_lcd_own = {8{~third_digital}}; // RQ12

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // first port: all six pins bidirectional, peripherals may take over
  pcdl_pin_cell #(.W(6)) u_first (
    .pclk(pclk),
    .presetn(presetn),
    .bidir_mask(`PCDL_FIRST_BIDIR_MASK),
    .latch(r_q.first_data),
    .dir(r_q.first_dir),
    .lcd_own(6'h00),
    .lcd_value(6'h00),
    .periph_en(periph_en), // RQ5 RQ17
    .periph_out(periph_out),
    .periph_oe(periph_oe),
    .pin_out(first_port_pin_out),
    .pin_oe(first_port_pin_oe)
  );

  // second port: pins 5..7 can only listen once the lcd lets go
  pcdl_pin_cell #(.W(8)) u_second (
    .pclk(pclk),
    .presetn(presetn),
    .bidir_mask(`PCDL_SECOND_BIDIR_MASK), // RQ8
    .latch(r_q.second_data),
    .dir(r_q.second_dir),
    .lcd_own(second_lcd_own), // RQ11
    .lcd_value(lcd_second_drive),
    .periph_en(8'h00),
    .periph_out(8'h00),
    .periph_oe(8'h00),
    .pin_out(second_port_pin_out),
    .pin_oe(second_port_pin_oe)
  );

  // third port: input only; its direction word is storage with no effect
  pcdl_pin_cell #(.W(8)) u_third (
    .pclk(pclk),
    .presetn(presetn),
    .bidir_mask(`PCDL_NO_BIDIR_MASK), // RQ12
    .latch(8'h00),
    .dir(r_q.third_dir),
    .lcd_own(third_lcd_own), // RQ11
    .lcd_value(lcd_third_drive),
    .periph_en(8'h00),
    .periph_out(8'h00),
    .periph_oe(8'h00),
    .pin_out(third_port_pin_out),
    .pin_oe(third_port_pin_oe)
  );

endmodule

// ===== pcdl_defs.svh
`ifndef PCDL_DEFS_SVH
`define PCDL_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define PCDL_IDX_FIRST_DATA 12'h007
`define PCDL_IDX_SECOND_DATA 12'h008
`define PCDL_IDX_THIRD_DATA 12'h009
`define PCDL_IDX_FIRST_DIR 12'h087
`define PCDL_IDX_SECOND_DIR 12'h088
`define PCDL_IDX_THIRD_DIR 12'h089
`define PCDL_IDX_SEG_ENABLE 12'h10D

// reset values
`define PCDL_RST_FIRST_DATA 6'h00
`define PCDL_RST_FIRST_DIR 6'h3F
`define PCDL_RST_PORT_DATA 8'h00
`define PCDL_RST_PORT_DIR 8'hFF
`define PCDL_RST_SEG_ENABLE 8'hFF

// segment-enable field positions, bit 7 down: 29 27 20 16 12 9 5 0
`define PCDL_SE_GROUP_0 0
`define PCDL_SE_GROUP_5 1
`define PCDL_SE_GROUP_9 2
`define PCDL_SE_GROUP_12 3
`define PCDL_SE_GROUP_16 4
`define PCDL_SE_GROUP_20 5
`define PCDL_SE_GROUP_27 6
`define PCDL_SE_GROUP_29 7

// bidirectional pin masks: second port, first port, none
`define PCDL_SECOND_BIDIR_MASK 8'h1F
`define PCDL_FIRST_BIDIR_MASK 6'h3F
`define PCDL_NO_BIDIR_MASK 8'h00

`endif

// ===== pcdl_pkg.sv
package pcdl_pkg;

  // apb slave phase, one-hot
  typedef enum logic [2:0] {
    PCDL_IDLE = 3'b001,
    PCDL_WAIT = 3'b010,
    PCDL_DONE = 3'b100
  } pcdl_phase_t;

  typedef struct packed {
    pcdl_phase_t phase;
    logic ready;
    logic err;
  } pcdl_apb_state_t;

  typedef struct packed {
    logic [5:0] first_data;
    logic [5:0] first_dir;
    logic [7:0] second_data;
    logic [7:0] second_dir;
    logic [7:0] third_dir;
    logic [7:0] seg_enable;
    logic [31:0] rdata;
    logic third_pin7_digital;
  } pcdl_regs_t;

endpackage

// ===== pcdl_pin_cell.sv
`timescale 1ns/100ps
`include "pcdl_defs.svh"

module pcdl_pin_cell import pcdl_pkg::*; #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] bidir_mask,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] lcd_own,
  input wire logic [W-1:0] lcd_value,
  input wire logic [W-1:0] periph_en,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] periph_oe,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);

  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe;
  } pcdl_cell_t;

  pcdl_cell_t s_q;
  pcdl_cell_t s_d;

  // per pin: lcd first, then an enabled peripheral, then the port latch
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < W; i++) begin
      if (lcd_own[i]) begin
        s_d.out[i] = lcd_value[i]; // RQ11
        s_d.oe[i] = 1'b1;
      end else if (periph_en[i]) begin
        s_d.out[i] = periph_out[i]; // RQ17
        s_d.oe[i] = periph_oe[i];
      end else if (bidir_mask[i]) begin
        s_d.out[i] = latch[i];
        s_d.oe[i] = ~dir[i]; // RQ2 RQ8
      end else begin
        // input-only pins never drive once the lcd lets go
        s_d.out[i] = 1'b0;
        s_d.oe[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.out;
  assign pin_oe = s_q.oe;

endmodule

// ===== pcdl_apb_slave.sv
`timescale 1ns/100ps
`include "pcdl_defs.svh"

module pcdl_apb_slave import pcdl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic addr_hit,
  output logic prep,
  output logic commit,
  output logic pready,
  output logic pslverr
);

  pcdl_apb_state_t s_q;
  pcdl_apb_state_t s_d;

  // one wait state: the first access cycle prepares read data,
  // the second raises pready; a fixed answer keeps the bench simple
  always_comb begin
    s_d = s_q;
    case (s_q.phase)
      PCDL_IDLE: begin
        if (psel && penable) begin
          s_d.phase = PCDL_WAIT;
          s_d.ready = 1'b1;
          s_d.err = ~addr_hit;
        end
      end
      PCDL_WAIT: begin
        s_d.phase = PCDL_DONE;
        s_d.ready = 1'b0;
        s_d.err = 1'b0;
      end
      PCDL_DONE: begin
        s_d.phase = PCDL_IDLE;
      end
      default: begin
        s_d.phase = PCDL_IDLE;
        s_d.ready = 1'b0;
        s_d.err = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{phase: PCDL_IDLE, ready: 1'b0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prep = (s_q.phase == PCDL_IDLE) && psel && penable;
  // writes land only at the edge where pready is seen high
  assign commit = (s_q.phase == PCDL_WAIT) && psel && penable;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;

endmodule

// ===== pcdl_props.sv
`timescale 1ns/100ps
module pcdl_props import pcdl_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] first_port_pin_oe,
  input wire logic [5:0] periph_en,
  input wire logic [5:0] periph_oe,
  input wire logic [7:0] second_port_pin_oe,
  input wire logic [7:0] third_port_pin_oe,
  input wire logic [7:0] seg_pin_enable,
  input wire logic sixth_port_pin7_digital
);
  logic settle_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pins lag one edge; a reset edge breaks that lag, so skip the cycle after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 1'b0;
    end else begin
      settle_q <= !sys_reset_req;
    end
  end
  ////////////////////////////////////////////////////////////////
  // ownership of pins and the bus answer
  chk_low_lcd: assert property (
    settle_q && seg_pin_enable[0] && $past(seg_pin_enable[0]) |-> &second_port_pin_oe[4:0])
    else $error("low second pins not lcd driven");
  chk_high_lcd: assert property (
    settle_q && seg_pin_enable[7] && $past(seg_pin_enable[7]) |-> &second_port_pin_oe[7:5])
    else $error("high second pins not lcd driven");
  chk_high_input: assert property (
    settle_q && !seg_pin_enable[7] && !$past(seg_pin_enable[7])
    |-> second_port_pin_oe[7:5] == 3'h0) else $error("input only pins driven");
  chk_third_input: assert property (
    settle_q && (seg_pin_enable & 8'h46) == 8'h00 && ($past(seg_pin_enable) & 8'h46) == 8'h00
    |-> third_port_pin_oe == 8'h00) else $error("third port driven while digital");
  chk_sixth_free: assert property (
    settle_q && seg_pin_enable == $past(seg_pin_enable)
    && seg_pin_enable == $past(seg_pin_enable, 2)
    |-> sixth_port_pin7_digital == ((seg_pin_enable & 8'h46) == 8'h00))
    else $error("sixth pin release wrong");
  chk_ready_wait: assert property (
    psel && penable && !pready && !$past(penable) |=> pready ##1 !pready)
    else $error("access not answered after one wait");
  chk_err_map: assert property (
    pready |-> pslverr == !(paddr inside {12'h01C, 12'h020, 12'h024, 12'h21C, 12'h220,
    12'h224, 12'h434})) else $error("error answer wrong for address");
  chk_periph_over: assert property (
    settle_q |-> ((first_port_pin_oe ^ $past(periph_oe)) & $past(periph_en)) == 6'h00)
    else $error("peripheral lost pin direction");
  chk_reset_own: assert property (
    $rose(presetn) |=> &second_port_pin_oe && &third_port_pin_oe
    && (first_port_pin_oe & ~$past(periph_en)) == 6'h00) else $error("pins not in reset state");
endmodule

bind pcdl_port_mux pcdl_props u_pcdl_props (.pclk, .presetn, .sys_reset_req, .psel, .penable,
  .paddr, .pready, .pslverr, .first_port_pin_oe, .periph_en, .periph_oe, .second_port_pin_oe,
  .third_port_pin_oe, .seg_pin_enable, .sixth_port_pin7_digital);

// ===== pcdl_pin_model.sv
`timescale 1ns/100ps
module pcdl_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_level,
  output logic [W-1:0] pin_level
);
  ////////////////////////////////////////////////////////////////
  // board side: a released pin shows the board level, never its old value
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== test_ports_c_d_e_lcd_pin_mux.sv
`timescale 1ns/100ps
module test_ports_c_d_e_lcd_pin_mux import pcdl_pkg::*;;
  localparam logic [11:0] reg_addr [7] = '{12'h01C, 12'h020, 12'h024, 12'h21C, 12'h220,
    12'h224, 12'h434};
  logic pclk, presetn, sys_reset_req, psel, penable, pwrite, pready, pslverr, err;
  logic sixth_port_pin7_digital;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] first_port_pin_in, first_port_pin_out, first_port_pin_oe, first_ext;
  logic [5:0] periph_en, periph_out, periph_oe;
  logic [7:0] second_port_pin_in, second_port_pin_out, second_port_pin_oe, second_ext;
  logic [7:0] third_port_pin_in, third_port_pin_out, third_port_pin_oe, third_ext;
  logic [7:0] lcd_second_drive, lcd_third_drive, seg_pin_enable;
  int fail_count, compares, cycles, seed;
  int m_fdata, m_fdir, m_sdata, m_sdir, m_tdir, m_seg;

  pcdl_port_mux u_pcdl_port_mux (.pclk, .presetn, .sys_reset_req, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .first_port_pin_in, .first_port_pin_out,
    .first_port_pin_oe, .periph_en, .periph_out, .periph_oe, .second_port_pin_in,
    .second_port_pin_out, .second_port_pin_oe, .lcd_second_drive, .third_port_pin_in,
    .third_port_pin_out, .third_port_pin_oe, .lcd_third_drive, .seg_pin_enable,
    .sixth_port_pin7_digital);
  // board level of each port
  pcdl_pin_model #(.W(6)) u_first_pins (.pin_out(first_port_pin_out),
    .pin_oe(first_port_pin_oe), .ext_level(first_ext), .pin_level(first_port_pin_in));
  pcdl_pin_model #(.W(8)) u_second_pins (.pin_out(second_port_pin_out),
    .pin_oe(second_port_pin_oe), .ext_level(second_ext), .pin_level(second_port_pin_in));
  pcdl_pin_model #(.W(8)) u_third_pins (.pin_out(third_port_pin_out),
    .pin_oe(third_port_pin_oe), .ext_level(third_ext), .pin_level(third_port_pin_in));

  ////////////////////////////////////////////////////////////////
  // clock and hang guard; a run needs well under 3000 cycles
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write a register and keep the model in step; third data takes no write
  task automatic put(input int i, input int v);
    apb(1'b1, reg_addr[i], v);
    check(err, 1'b0);
    case (i)
      0: m_fdata = v & 32'h3F;
      1: m_sdata = v & 32'hFF;
      3: m_fdir = v & 32'h3F;
      4: m_sdir = v & 32'hFF;
      5: m_tdir = v & 32'hFF;
      6: m_seg = v & 32'hFF;
      default: ;
    endcase
  endtask

  task automatic model_reset();
    m_fdir = 32'h3F;
    m_sdata = 0;
    {m_sdir, m_tdir, m_seg} = {3{32'hFF}};
  endtask

  // new board, lcd and peripheral levels, then let the pins settle
  task automatic shake(input logic pe);
    @(posedge pclk);
    periph_en <= pe ? 6'($random(seed)) : 6'h0;
    periph_out <= 6'($random(seed));
    periph_oe <= 6'($random(seed));
    first_ext <= 6'($random(seed));
    {second_ext, third_ext} <= 16'($random(seed));
    {lcd_second_drive, lcd_third_drive} <= 16'($random(seed));
    repeat (2) @(posedge pclk);
  endtask

  // read every register; data registers show the pin levels the model predicts
  task automatic check_all();
    logic [5:0] fd;
    logic [7:0] own, sd;
    logic [31:0] ex [7];
    fd = (periph_en & periph_oe) | (~periph_en & ~m_fdir[5:0]);
    ex[0] = (fd & ((periph_en & periph_out) | (~periph_en & m_fdata[5:0]))) | (~fd & first_ext);
    own = {{3{m_seg[7]}}, {5{m_seg[0]}}};
    sd = own | {3'h0, ~m_sdir[4:0]};
    ex[1] = (sd & ((own & lcd_second_drive) | (~own & m_sdata[7:0]))) | (~sd & second_ext);
    ex[2] = (m_seg & 32'h46) != 0 ? lcd_third_drive : third_ext;
    ex[3] = m_fdir;
    ex[4] = m_sdir;
    ex[5] = m_tdir;
    ex[6] = m_seg;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, reg_addr[i], 32'h0);
      check(rd, ex[i]);
    end
    check(sixth_port_pin7_digital, (m_seg & 32'h46) == 0);
    check(seg_pin_enable, m_seg);
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    seed = 32'h68646F12;
    {sys_reset_req, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    {periph_en, periph_out, periph_oe, first_ext} = 24'h0;
    {second_ext, third_ext, lcd_second_drive, lcd_third_drive} = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    model_reset();
    shake(1'b0);
    check_all();
    put(6, 0);
    put(3, 32'hCF);
    repeat (2) @(posedge pclk);
    check(first_port_pin_oe, 6'h30);
    check_all();
    apb(1'b0, 12'h030, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 12'h438, 32'h0);
    check(err, 1'b1);
    for (int n = 0; n < 24; n++) begin
      for (int i = 0; i < 7; i++) put(i, $random(seed));
      shake(n[0]);
      check_all();
    end
    sys_reset_req <= 1'b1;
    repeat (3) @(posedge pclk);
    sys_reset_req <= 1'b0;
    model_reset();
    check_all();
    put(6, 0);
    put(3, 0);
    put(4, 0);
    shake(1'b0);
    check_all();
    finish_test();
  end
endmodule
